// File: core/nvc_ctrl.sv
// Top of the nonvolatile data array access controller, an APB slave.
// Assumes warm reset inputs and programmer port are synchronous to pclk.
//
// Behaviour
// - 256 byte locations, 8-bit index, byte data
// - Each write erases the location, then programs
// - Internal timer sets write length
// - Protected: programmer reads zero, processor unaffected
// - Control upper four bits read zero
// - Triggers set by software, cleared by hardware
// - Write permit gates writes, cleared at power-up
// - Reset during write sets abort flag
// - Aborting reset clears data and index
// - Write completion sets done flag, software clears
// - Unlock port stores nothing, reads zero
// - Read: load index, trigger, one-cycle completion
// - Read data present the next cycle
// - Data register holds last read value
// - Write needs 55h, AAh, trigger, exact spacing
// - Write trigger blocked unless permit already set
// - Permit cleared by hardware only at power-up and on warm reset, even mid-write
// - Writes blocked during power-up timer
`timescale 1ns/1ps
module nvc_ctrl
    import nvc_pkg::*;
#(
    parameter int unsigned PWRT_CYCLES = NVC_PWRT_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 ext_clear_rst,
    input  wire logic                 watchdog_timeout,
    input  wire logic                 brownout_rst,
    input  wire logic                 data_protect_setting,
    input  wire logic                 prog_rd_en,
    input  wire logic [NVC_IDX_W-1:0] prog_addr,
    output logic      [NVC_DW-1:0]    prog_rd_data,
    output logic                      write_busy,
    output logic                      write_done_flag
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0]          prdata_r;
    logic [31:0]          rdata_nxt;
    logic                 pready_r;
    logic                 pslverr_r;
    logic                 hit;
    logic [NVC_DW-1:0]    data_r;
    logic [NVC_IDX_W-1:0] index_r;
    nvc_ctrl_type         ctrl_r;
    logic                 done_r;
    logic [NVC_DW-1:0]    prog_r;
    nvc_wstate_type       wst_r;
    nvc_unlock_type       ul_r;
    logic [1:0]           gap_r;
    logic [NVC_IDX_W-1:0] lat_addr_r;
    logic [NVC_DW-1:0]    lat_data_r;
    logic [8:0]           wr_age_r;
    logic                 setup;
    logic                 acc;
    logic                 wr_acc;
    logic                 sel_data;
    logic                 sel_index;
    logic                 sel_ctrl;
    logic                 sel_unlock;
    logic                 sel_flag;
    logic                 warm;
    logic                 gap_ok;
    logic                 rd_req;
    logic                 wr_req;
    logic                 wr_start;
    logic                 wr_done;
    logic                 pwrt_busy;
    logic                 tmr_load;
    logic [NVC_WTMR_W-1:0] tmr_val;
    logic                 tmr_exp;
    logic                 arr_we;
    logic [NVC_IDX_W-1:0] arr_addr;
    logic [NVC_DW-1:0]    arr_wdata;
    logic [NVC_DW-1:0]    arr_rdata;
    logic [NVC_DW-1:0]    arr_prog_rdata;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Writes act only at the access edge the master samples pready
    assign setup      = psel && !penable;
    assign acc        = psel && penable && pready_r;
    assign wr_acc     = acc && pwrite;
    assign sel_data   = (paddr == NVC_OFF_DATA);
    assign sel_index  = (paddr == NVC_OFF_INDEX);
    assign sel_ctrl   = (paddr == NVC_OFF_CTRL);
    assign sel_unlock = (paddr == NVC_OFF_UNLOCK);
    assign sel_flag   = (paddr == NVC_OFF_FLAG);
    assign warm       = ext_clear_rst || watchdog_timeout || brownout_rst;

    // Read mux, evaluated in the setup cycle
    always_comb begin
        rdata_nxt = '0;
        hit       = 1'b1;
        if (sel_data) begin
            rdata_nxt[NVC_DW-1:0] = data_r;
        end else if (sel_index) begin
            rdata_nxt[NVC_IDX_W-1:0] = index_r;
        end else if (sel_ctrl) begin
            rdata_nxt[3:0] = ctrl_r;
        end else if (sel_unlock) begin
            rdata_nxt = '0;
        end else if (sel_flag) begin
            rdata_nxt[NVC_FLAG_DONE] = done_r;
        end else begin
            hit = 1'b0;
        end
    end

    // Zero-wait answer: pready for exactly the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !hit;
            if (setup) begin
                prdata_r <= pwrite ? '0 : rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    // Any other access, or any gap other than back-to-back, breaks it
    assign gap_ok = (gap_r == 2'(NVC_UNLOCK_SPACING_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ul_r  <= UL_IDLE;
            gap_r <= '0;
        end else if (warm) begin
            ul_r  <= UL_IDLE;
            gap_r <= '0;
        end else if (acc) begin
            gap_r <= '0;
            if (pwrite && sel_unlock && pwdata[7:0] == NVC_KEY1) begin
                ul_r <= UL_KEY1;
            end else if (pwrite && sel_unlock && pwdata[7:0] == NVC_KEY2 && ul_r == UL_KEY1 && gap_ok) begin
                ul_r <= UL_KEY2;
            end else begin
                ul_r <= UL_IDLE;
            end
        end else if (gap_r != 2'h3) begin
            gap_r <= gap_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------
    // Permit is checked before this write lands, never from its own data
    assign rd_req   = wr_acc && sel_ctrl && pwdata[NVC_CTRL_RD];
    assign wr_req   = wr_acc && sel_ctrl && pwdata[NVC_CTRL_WR];
    assign wr_start = wr_req && !rd_req
                   && !ctrl_r.wr && ctrl_r.permit
                   && ul_r == UL_KEY2 && gap_ok
                   && !pwrt_busy && !warm;
    assign wr_done  = (wst_r == WS_PROG) && tmr_exp;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Warm reset branch sits apart, so its abort set beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= NVC_CTRL_RST;
        end else if (warm) begin
            ctrl_r.rd     <= 1'b0;
            ctrl_r.wr     <= 1'b0;
            ctrl_r.permit <= 1'b0;
            if (ctrl_r.wr) begin
                ctrl_r.abort <= 1'b1;
            end
        end else begin
            if (ctrl_r.rd) begin
                ctrl_r.rd <= 1'b0;
            end else if (rd_req) begin
                ctrl_r.rd <= 1'b1;
            end
            if (wr_done) begin
                ctrl_r.wr <= 1'b0;
            end else if (wr_start) begin
                ctrl_r.wr <= 1'b1;
            end
            if (wr_acc && sel_ctrl) begin
                ctrl_r.permit <= pwdata[NVC_CTRL_PERMIT];
                ctrl_r.abort  <= pwdata[NVC_CTRL_ABORT];
            end
        end
    end

    // ------------------------------------------------------------
    // Data and index registers
    // ------------------------------------------------------------
    // Read result lands one cycle after the trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= NVC_DATA_RST;
        end else if (warm) begin
            data_r <= NVC_DATA_RST;
        end else if (ctrl_r.rd) begin
            data_r <= arr_rdata;
        end else if (wr_acc && sel_data) begin
            data_r <= pwdata[NVC_DW-1:0];
        end
    end

    // Location index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_r <= NVC_IDX_RST;
        end else if (warm) begin
            index_r <= NVC_IDX_RST;
        end else if (wr_acc && sel_index) begin
            index_r <= pwdata[NVC_IDX_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Write sequencer
    // ------------------------------------------------------------
    // Address and data are latched so stray register writes cannot corrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_r      <= WS_IDLE;
            lat_addr_r <= '0;
            lat_data_r <= '0;
        end else if (warm) begin
            wst_r <= WS_IDLE;
        end else begin
            case (wst_r)
                WS_IDLE: begin
                    if (wr_start) begin
                        wst_r      <= WS_ERASE;
                        lat_addr_r <= index_r;
                        lat_data_r <= data_r;
                    end
                end
                WS_ERASE: begin
                    if (tmr_exp) begin
                        wst_r <= WS_PROG;
                    end
                end
                WS_PROG: begin
                    if (tmr_exp) begin
                        wst_r <= WS_IDLE;
                    end
                end
                default: begin
                    wst_r <= WS_IDLE;
                end
            endcase
        end
    end

    // Array strobes: erase at start, program when erase time ends
    always_comb begin
        arr_we    = wr_start || (wst_r == WS_ERASE && tmr_exp && !warm);
        arr_addr  = wr_start ? index_r : lat_addr_r;
        arr_wdata = wr_start ? NVC_ERASED : lat_data_r;
        tmr_load  = wr_start || (wst_r == WS_ERASE && tmr_exp) || warm;
        tmr_val   = '0;
        if (wr_start) begin
            tmr_val = NVC_WTMR_W'(NVC_ERASE_CYC);
        end else if (!warm) begin
            tmr_val = NVC_WTMR_W'(NVC_PROG_CYC);
        end
    end

    // ------------------------------------------------------------
    // Done flag and programmer port
    // ------------------------------------------------------------
    // Completion beats a clear arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (warm) begin
            done_r <= 1'b0;
        end else if (wr_done) begin
            done_r <= 1'b1;
        end else if (wr_acc && sel_flag && !pwdata[NVC_FLAG_DONE]) begin
            done_r <= 1'b0;
        end
    end

    // Protected array shows zeros to the programmer only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_r <= '0;
        end else if (prog_rd_en) begin
            prog_r <= data_protect_setting ? '0 : arr_prog_rdata;
        end
    end

    // ------------------------------------------------------------
    // Instances and outputs
    // ------------------------------------------------------------
    nvc_timer #(.W(NVC_WTMR_W), .INIT('0)) u_wtmr (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tmr_load),
        .value   (tmr_val),
        .busy    (),
        .expire  (tmr_exp)
    );

    // Starts counting straight out of reset; long, so a parameter
    nvc_timer #(.W(NVC_PTMR_W), .INIT(NVC_PTMR_W'(PWRT_CYCLES))) u_pwrt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (1'b0),
        .value   ('0),
        .busy    (pwrt_busy),
        .expire  ()
    );

    nvc_array u_array (
        .pclk    (pclk),
        .we      (arr_we),
        .waddr   (arr_addr),
        .wdata   (arr_wdata),
        .raddr_a (index_r),
        .rdata_a (arr_rdata),
        .raddr_b (prog_addr),
        .rdata_b (arr_prog_rdata)
    );

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign prog_rd_data    = prog_r;
    assign write_busy      = ctrl_r.wr;
    assign write_done_flag = done_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Age of the running write, for the duration check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_age_r <= '0;
        end else if (!ctrl_r.wr) begin
            wr_age_r <= '0;
        end else begin
            wr_age_r <= wr_age_r + 9'h001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_read_one_cycle: assert property (ctrl_r.rd && !warm |=> !ctrl_r.rd && data_r == $past(arr_rdata))
        else $error("read did not complete in one cycle");
    a_write_gated: assert property ($rose(ctrl_r.wr) |-> $past(ctrl_r.permit && ul_r == UL_KEY2 && !pwrt_busy))
        else $error("write started without permit, unlock or timer");
    a_write_length: assert property (wr_done && !warm |-> wr_age_r == 9'(NVC_ERASE_CYC + NVC_PROG_CYC - 1))
        else $error("write length wrong");
    a_erase_first: assert property (wr_start |-> arr_we && arr_wdata == NVC_ERASED ##1 !arr_we)
        else $error("write did not erase first");
    a_done_flag_set: assert property (wr_done && !warm |=> done_r && !ctrl_r.wr)
        else $error("completion did not set done flag");
    a_abort_clears: assert property (ctrl_r.wr && warm |=> ctrl_r.abort && data_r == 8'h00 && index_r == 8'h00)
        else $error("aborted write not flagged");
    a_wr_no_sw_clear: assert property (ctrl_r.wr && !wr_done && !warm |=> ctrl_r.wr)
        else $error("write trigger cleared early");
    a_ctrl_upper_zero: assert property (setup && !pwrite && sel_ctrl |=> prdata[31:4] == 28'h0000000)
        else $error("control upper bits not zero");
    a_unlock_zero: assert property (setup && sel_unlock |=> prdata == 32'h00000000)
        else $error("unlock port read not zero");
    a_protect_zero: assert property (prog_rd_en && data_protect_setting |=> prog_rd_data == 8'h00)
        else $error("protected array visible to programmer");
    a_data_holds: assert property (!ctrl_r.rd && !warm && !(wr_acc && sel_data) |=> $stable(data_r))
        else $error("data register changed unprompted");

    c_read: cover property (ctrl_r.rd ##1 !ctrl_r.rd);
    c_write_done: cover property (wr_done ##1 done_r);
    c_abort: cover property (ctrl_r.wr && warm);
    c_both_triggers: cover property (rd_req && wr_req);

endmodule // nvc_ctrl

// File: core/nvc_pkg.sv
// Package for the nonvolatile data array access controller.
// Assumes a 40 MHz APB clock; the power-up count below derives from it.
package nvc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned NVC_CLK_HZ    = 40_000_000;
    localparam int unsigned NVC_PWRT_MS   = 64;
    localparam int unsigned NVC_PWRT_CYC  = NVC_PWRT_MS * (NVC_CLK_HZ / 1000);
    localparam int unsigned NVC_ERASE_CYC = 16;
    localparam int unsigned NVC_PROG_CYC  = 16;
    localparam int          NVC_WTMR_W    = 8;
    localparam int          NVC_PTMR_W    = 22;
    localparam int          NVC_UNLOCK_SPACING_CYC = 2;

    // ------------------------------------------------------------
    // Array geometry and keys
    // ------------------------------------------------------------
    localparam int          NVC_DEPTH  = 256;
    localparam int          NVC_IDX_W  = 8;
    localparam int          NVC_DW     = 8;
    localparam logic [7:0]  NVC_ERASED = 8'hFF;
    localparam logic [7:0]  NVC_KEY1   = 8'h55;
    localparam logic [7:0]  NVC_KEY2   = 8'hAA;

    // ------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  NVC_OFF_DATA   = 8'h00;
    localparam logic [7:0]  NVC_OFF_INDEX  = 8'h04;
    localparam logic [7:0]  NVC_OFF_CTRL   = 8'h08;
    localparam logic [7:0]  NVC_OFF_UNLOCK = 8'h0C;
    localparam logic [7:0]  NVC_OFF_FLAG   = 8'h10;
    localparam int          NVC_CTRL_RD     = 0;
    localparam int          NVC_CTRL_WR     = 1;
    localparam int          NVC_CTRL_PERMIT = 2;
    localparam int          NVC_CTRL_ABORT  = 3;
    localparam int          NVC_FLAG_DONE   = 7;
    localparam logic [7:0]  NVC_DATA_RST    = 8'h00;
    localparam logic [7:0]  NVC_IDX_RST     = 8'h00;

    typedef struct packed {
        logic abort;
        logic permit;
        logic wr;
        logic rd;
    } nvc_ctrl_type;

    localparam nvc_ctrl_type NVC_CTRL_RST = '0;

    typedef enum {WS_IDLE, WS_ERASE, WS_PROG} nvc_wstate_type;
    typedef enum {UL_IDLE, UL_KEY1, UL_KEY2} nvc_unlock_type;

endpackage

// File: core/nvc_timer.sv
// Down-counting timer with a reset load value and an expiry pulse.
// Assumes load and value are synchronous to pclk.
`timescale 1ns/1ps
module nvc_timer
    import nvc_pkg::*;
#(
    parameter int          W    = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              busy,
    output logic              expire
);
    logic [W-1:0] cnt_r;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Reload wins over counting, so a restart never loses a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= INIT;
        end else if (load) begin
            cnt_r <= value;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Expiry on the last counted cycle; kept free of load, since the
    // caller derives load from expire and would otherwise close a loop
    assign busy   = (cnt_r != '0);
    assign expire = (cnt_r == W'(1));

endmodule // nvc_timer

// File: core/nvc_array.sv
// Byte array with one write port and two combinational read ports.
// Assumes writes are single-cycle strobes from the controller.
`timescale 1ns/1ps
module nvc_array
    import nvc_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 we,
    input  wire logic [NVC_IDX_W-1:0] waddr,
    input  wire logic [NVC_DW-1:0]    wdata,
    input  wire logic [NVC_IDX_W-1:0] raddr_a,
    output logic      [NVC_DW-1:0]    rdata_a,
    input  wire logic [NVC_IDX_W-1:0] raddr_b,
    output logic      [NVC_DW-1:0]    rdata_b
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // No reset: contents are nonvolatile in intent
    logic [NVC_DW-1:0] mem [NVC_DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Reads need no clock so a read lands in one cycle
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule // nvc_array

// File: dv/tb.sv
// Bench for the nonvolatile array controller: APB tasks and scenarios.
// Assumes the zero-wait slave and a 20-cycle power-up count.
`timescale 1ns/1ps
module tb
    import nvc_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err_seen;
    logic        ext_clr = 0, wdog = 0, brown = 0, prot = 0, pren = 0, busy, done;
    logic [7:0]  paddr = '0, pidx = '0, pdat;
    logic [31:0] pwdata = '0, prdata, rdv;
    int          n_mismatch = 0, compares = 0;
    // ------------------------------------------------------------
    // Clock, device
    // ------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    nvc_ctrl #(.PWRT_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clear_rst(ext_clr), .watchdog_timeout(wdog), .brownout_rst(brown), .data_protect_setting(prot),
        .prog_rd_en(pren), .prog_addr(pidx), .prog_rd_data(pdat), .write_busy(busy), .write_done_flag(done));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Bus stays held after the answer so back-to-back setups are possible
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_mismatch++;
            summarize();
        end
        rdv      = prdata;
        err_seen = pslverr;
    endtask
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        idle();
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        idle();
    endtask
    // A gap between the keys must break the unlock
    task automatic unlock_go(input logic gap);
        apb(1'b1, NVC_OFF_UNLOCK, 32'h55);
        if (gap) idle();
        apb(1'b1, NVC_OFF_UNLOCK, 32'hAA);
        wr(NVC_OFF_CTRL, 32'h6);
    endtask
    task automatic prog(input logic [7:0] a);
        pren <= 1'b1;
        pidx <= a;
        @(posedge pclk);
        pren <= 1'b0;
        @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_block();
        wr(NVC_OFF_CTRL, 32'h4);
        unlock_go(1'b0);
        chk(busy, 0);
        repeat (20) @(posedge pclk);
        unlock_go(1'b1);
        chk(busy, 0);
        wr(NVC_OFF_CTRL, 32'h0);
        unlock_go(1'b0);
        chk(busy, 0);
        $display("blocked writes test done");
    endtask
    task automatic t_write();
        int n = 0;
        wr(NVC_OFF_DATA, 32'h5A);
        wr(NVC_OFF_INDEX, 32'h3C);
        unlock_go(1'b0);
        chk(busy, 1);
        // Registers left alone while the write runs
        while (busy === 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            summarize();
        end
        chk(n, NVC_ERASE_CYC + NVC_PROG_CYC);
        chk(done, 1);
        rd(NVC_OFF_CTRL);
        chk(rdv, 32'h4);
        wr(NVC_OFF_FLAG, 32'h80);
        chk(done, 1);
        wr(NVC_OFF_FLAG, 32'h0);
        chk(done, 0);
        prog(8'h3C);
        chk(pdat, 8'h5A);
        prot <= 1'b1;
        prog(8'h3C);
        chk(pdat, 8'h00);
        // Processor read must still work while protected
        wr(NVC_OFF_DATA, 32'h0);
        wr(NVC_OFF_CTRL, 32'h5);
        rd(NVC_OFF_DATA);
        chk(rdv, 32'h5A);
        rd(NVC_OFF_CTRL);
        chk(rdv, 32'h4);
        prot <= 1'b0;
        $display("write and read test done");
    endtask
    // Each warm reset source in turn cuts a running write
    task automatic t_abort();
        for (int k = 0; k < 3; k++) begin
            wr(NVC_OFF_CTRL, 32'h4);
            wr(NVC_OFF_DATA, 32'h11);
            wr(NVC_OFF_INDEX, 32'h20);
            unlock_go(1'b0);
            ext_clr <= (k == 0);
            wdog    <= (k == 1);
            brown   <= (k == 2);
            @(posedge pclk);
            ext_clr <= 1'b0;
            wdog    <= 1'b0;
            brown   <= 1'b0;
            rd(NVC_OFF_CTRL);
            chk(rdv, 32'h8);
            rd(NVC_OFF_DATA);
            chk(rdv, 32'h0);
            rd(NVC_OFF_INDEX);
            chk(rdv, 32'h0);
        end
        $display("abort test done");
    endtask
    task automatic t_regs();
        wr(NVC_OFF_CTRL, 32'hFC);
        rd(NVC_OFF_CTRL);
        chk(rdv, 32'hC);
        rd(NVC_OFF_UNLOCK);
        chk(rdv, 32'h0);
        wr(NVC_OFF_DATA, 32'hA5);
        rd(NVC_OFF_DATA);
        chk(rdv, 32'hA5);
        rd(8'h14);
        chk(err_seen, 1);
        // Both triggers after a good unlock: only the read is served
        wr(NVC_OFF_INDEX, 32'h20);
        apb(1'b1, NVC_OFF_UNLOCK, 32'h55);
        apb(1'b1, NVC_OFF_UNLOCK, 32'hAA);
        wr(NVC_OFF_CTRL, 32'h7);
        chk(busy, 0);
        rd(NVC_OFF_DATA);
        chk(rdv, 32'hFF);
        $display("register test done");
    endtask
    // Reset 12 cycles, then scenarios in order
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_block();
        t_write();
        t_abort();
        t_regs();
        summarize();
    end
endmodule // tb
